// ### pkg/sfs_cfg.svh
// Constants of the synthesizer serial load and control block.
// Assumes a 200 MHz mclk; included by bare name where needed.
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// Clock and timing
`define SFS_CLK_PERIOD_PS 5000
`define SFS_LOCK_WIN_NS 15
`define SFS_LOCK_WIN_CYC (((`SFS_LOCK_WIN_NS * 1000) + `SFS_CLK_PERIOD_PS - 1) / `SFS_CLK_PERIOD_PS)
`define SFS_LOCK_GOOD 4

// Serial word layout
`define SFS_SHIFT_W 19
`define SFS_REF_W 14
`define SFS_RF_W 18
`define SFS_CTRL_REF 1'b1
`define SFS_REF_RST 14'h0_00A
`define SFS_RF_RST 18'h0_0064

// Synchronizer reset levels; strobe, polarity and power save idle high
`define SFS_PIN_RST 7'h1C

// Register offsets
`define SFS_OFF_STATUS 8'h00
`define SFS_OFF_MASK 8'h04
`define SFS_OFF_STATE 8'h08
`define SFS_OFF_REFDIV 8'h0C
`define SFS_OFF_RFDIV 8'h10

// Status bit positions
`define SFS_ST_REFLOAD 0
`define SFS_ST_RFLOAD 1
`define SFS_ST_LOCKLOST 2
`define SFS_ST_PDENTER 3
`define SFS_ST_W 4

`endif

// ### pkg/sfs_pkg.sv
// Types of the synthesizer serial load and control block.
// Assumes nothing of its surroundings.
package sfs_pkg;
   // Power save sequencing
   typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_DOWN} sfs_pwr_t;
   // Sync input bundle index
   typedef enum int {PIN_SCLK, PIN_SDATA, PIN_LOAD, PIN_POL, PIN_PSN, PIN_OSC, PIN_RF, PIN_N}
      sfs_pin_t;
endpackage : sfs_pkg

// ### rtl/sfs_sync.sv
// Three-stage pin synchronizer with agreement filter and edge pulses.
// Assumes asynchronous pins; all outputs come from mclk flip-flops.
`timescale 1ns/1ps
module sfs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Pins
   input wire logic [W-1:0] pin_i,
   // Filtered view
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q, s2_q, s3_q;
         // First stage feeds only the second
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q <= RST_VAL[i];
               s2_q <= RST_VAL[i];
               s3_q <= RST_VAL[i];
            end else begin
               s1_q <= pin_i[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // Change counts once stages two and three agree
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               level_o[i] <= RST_VAL[i];
               rise_o[i] <= 1'b0;
               fall_o[i] <= 1'b0;
            end else begin
               rise_o[i] <= (s2_q == s3_q) && s3_q && !level_o[i];
               fall_o[i] <= (s2_q == s3_q) && !s3_q && level_o[i];
               if (s2_q == s3_q) begin
                  level_o[i] <= s3_q;
               end
            end
         end
      end
   endgenerate
endmodule : sfs_sync

// ### rtl/sfs_pfd.sv
// Phase frequency comparator feeding the charge pump pair.
// Assumes one-cycle event pulses from both dividers.
`timescale 1ns/1ps
module sfs_pfd (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Compare events
   input wire logic ref_evt,
   input wire logic div_evt,
   // Control
   input wire logic invert,
   input wire logic hold,
   // Pump drive
   output logic src_o,
   output logic snk_o
);
   logic up_q, dn_q;

   // Classic two-flop detector; both set means reset, no dead zone logic
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else if (hold || (up_q && dn_q)) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         up_q <= up_q | ref_evt;
         dn_q <= dn_q | div_evt;
      end
   end

   // Polarity swap; both sides low is the idle high-impedance pump
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_o <= 1'b0;
         snk_o <= 1'b0;
      end else begin
         src_o <= (invert ? dn_q : up_q) && !(up_q && dn_q) && !hold;
         snk_o <= (invert ? up_q : dn_q) && !(up_q && dn_q) && !hold;
      end
   end
endmodule : sfs_pfd

// ### rtl/sfs_top.sv
// Serial load port, dividers, pump control, lock and power save.
// Assumes the serial, static and frequency pins are asynchronous to mclk and the register port is synchronous; the host keeps the serial
// clock low around every load strobe edge and sends words MSB first.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sfs_cfg.svh"

// Overview of operation
// R1 - Shift data on each serial clock rise
// R2 - MSB first; last bit picks latch
// R3 - Strobe rise copies word into latch
// R4 - Host keeps serial clock low at strobe
// R5 - Low polarity select inverts pump sense
// R6 - Strobe high closes loop switch
// R7 - Power save low requests power down
// R8 - Power down waits for idle pump
// R9 - Lock high with narrow low pulses
// R10 - Monitor output shows divided comparator input
// R11 - Open drain and push-pull pump outputs
// R12 - Control bit and word lengths per layout
module sfs_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial port
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_strobe,
   // Static controls
   input wire logic phase_polarity_select,
   input wire logic power_save_n,
   // Frequency inputs
   input wire logic osc_ref_in,
   input wire logic rf_in,
   // Charge pump
   output logic pump_src,
   output logic pump_snk,
   output logic loop_switch_out,
   // External pump drive
   output logic pump_drain_out,
   output logic pump_drain_oe,
   output logic pump_logic_out,
   // Status pins
   output logic lock_indicator,
   output logic monitor_out,
   output logic powered_down,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   localparam int NP = sfs_pkg::PIN_N;
   localparam logic [NP-1:0] PIN_RST = `SFS_PIN_RST;
   localparam int LWC = `SFS_LOCK_WIN_CYC;

   logic [NP-1:0] pins, lvl, rise, fall;
   logic [`SFS_SHIFT_W-1:0] shift_q;
   logic [`SFS_REF_W-1:0] ref_div_q, ref_cnt_q;
   logic [`SFS_RF_W-1:0] rf_div_q, rf_cnt_q;
   logic ref_evt_q, rf_evt_q, ref_load, rf_load;
   sfs_pkg::sfs_pwr_t pwr_q;
   logic pump_busy, pump_idle, evt_d_q, lock_q, lock_lost, pd_enter;
   logic [3:0] win_q;
   logic [2:0] good_q;
   logic [`SFS_ST_W-1:0] status_q, mask_q, events;

   // Address match, shared by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Pin conditioning
   assign pins[sfs_pkg::PIN_SCLK] = ser_clk;
   assign pins[sfs_pkg::PIN_SDATA] = ser_data;
   assign pins[sfs_pkg::PIN_LOAD] = load_strobe;
   assign pins[sfs_pkg::PIN_POL] = phase_polarity_select;
   assign pins[sfs_pkg::PIN_PSN] = power_save_n;
   assign pins[sfs_pkg::PIN_OSC] = osc_ref_in;
   assign pins[sfs_pkg::PIN_RF] = rf_in;

   // Pulled-up pins reset high so a floating pin reads as idle
   sfs_sync #(.W(NP), .RST_VAL(PIN_RST)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_i(pins),
      .level_o(lvl),
      .rise_o(rise),
      .fall_o()
   );

   // Shift register; data path has the same latency as the clock path
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= '0;
      end else if (rise[sfs_pkg::PIN_SCLK]) begin
         shift_q <= {shift_q[`SFS_SHIFT_W-2:0], lvl[sfs_pkg::PIN_SDATA]}; // R1 R2
      end
   end

   // Strobe edges are clean only because the serial clock is held low
   assign ref_load = rise[sfs_pkg::PIN_LOAD] && (shift_q[0] == `SFS_CTRL_REF); // R4 R12
   assign rf_load = rise[sfs_pkg::PIN_LOAD] && (shift_q[0] != `SFS_CTRL_REF); // R12

   // Latch transfer on strobe rise, control bit drops out
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_div_q <= `SFS_REF_RST;
      end else if (ref_load) begin
         ref_div_q <= shift_q[`SFS_REF_W:1]; // R3 R2
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rf_div_q <= `SFS_RF_RST;
      end else if (rf_load) begin
         rf_div_q <= shift_q[`SFS_RF_W:1]; // R3
      end
   end

   // Reference divider; a zero ratio behaves as one
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_q <= '0;
         ref_evt_q <= 1'b0;
      end else begin
         ref_evt_q <= 1'b0;
         if (powered_down) begin
            ref_cnt_q <= '0;
         end else if (rise[sfs_pkg::PIN_OSC]) begin
            if (ref_cnt_q + 1'b1 >= ref_div_q) begin
               ref_cnt_q <= '0;
               ref_evt_q <= 1'b1;
            end else begin
               ref_cnt_q <= ref_cnt_q + 1'b1;
            end
         end
      end
   end

   // RF divider, same structure
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rf_cnt_q <= '0;
         rf_evt_q <= 1'b0;
      end else begin
         rf_evt_q <= 1'b0;
         if (powered_down) begin
            rf_cnt_q <= '0;
         end else if (rise[sfs_pkg::PIN_RF]) begin
            if (rf_cnt_q + 1'b1 >= rf_div_q) begin
               rf_cnt_q <= '0;
               rf_evt_q <= 1'b1;
            end else begin
               rf_cnt_q <= rf_cnt_q + 1'b1;
            end
         end
      end
   end

   // Comparator and pump pair
   sfs_pfd u_pfd (
      .mclk(mclk),
      .rst_n(rst_n),
      .ref_evt(ref_evt_q),
      .div_evt(rf_evt_q),
      .invert(!lvl[sfs_pkg::PIN_POL]), // R5
      .hold(powered_down),
      .src_o(pump_src),
      .snk_o(pump_snk)
   );

   assign pump_busy = pump_src | pump_snk;

   // A compare event one cycle back may still fire the pump next edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evt_d_q <= 1'b0;
      end else begin
         evt_d_q <= ref_evt_q | rf_evt_q;
      end
   end
   assign pump_idle = !pump_busy && !evt_d_q; // R8

   // Loop switch follows the strobe level
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         loop_switch_out <= 1'b0;
      end else begin
         loop_switch_out <= lvl[sfs_pkg::PIN_LOAD]; // R6
      end
   end

   // External pump drive: drain pin only ever pulls low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pump_drain_oe <= 1'b0;
         pump_logic_out <= 1'b0;
      end else begin
         pump_drain_oe <= pump_snk; // R11
         pump_logic_out <= pump_src; // R11
      end
   end
   assign pump_drain_out = 1'b0; // R11

   // Power save sequencing; gating on idle pump avoids a frequency jump
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= sfs_pkg::PWR_RUN;
      end else begin
         case (pwr_q)
            sfs_pkg::PWR_RUN: begin
               if (!lvl[sfs_pkg::PIN_PSN]) begin
                  pwr_q <= sfs_pkg::PWR_WAIT; // R7
               end
            end
            sfs_pkg::PWR_WAIT: begin
               if (lvl[sfs_pkg::PIN_PSN]) begin
                  pwr_q <= sfs_pkg::PWR_RUN;
               end else if (pump_idle) begin
                  pwr_q <= sfs_pkg::PWR_DOWN; // R8
               end
            end
            sfs_pkg::PWR_DOWN: begin
               if (lvl[sfs_pkg::PIN_PSN]) begin
                  pwr_q <= sfs_pkg::PWR_RUN; // R7
               end
            end
            default: begin
               pwr_q <= sfs_pkg::PWR_RUN;
            end
         endcase
      end
   end
   assign powered_down = (pwr_q == sfs_pkg::PWR_DOWN);
   assign pd_enter = (pwr_q == sfs_pkg::PWR_WAIT) && lvl[sfs_pkg::PIN_PSN] == 1'b0 && pump_idle;

   // Pump pulse width watch; a long pulse means phase error too large
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         win_q <= '0;
      end else if (!pump_busy) begin
         win_q <= '0;
      end else if (win_q != 4'hF) begin
         win_q <= win_q + 1'b1;
      end
   end

   // Lock needs several clean compares in a row, drops on one wide pulse
   assign lock_lost = lock_q && (win_q > 4'(LWC));
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= 1'b0;
         good_q <= '0;
      end else if (powered_down || win_q > 4'(LWC)) begin
         lock_q <= 1'b0; // R9
         good_q <= '0;
      end else if (ref_evt_q) begin
         if (good_q == 3'(`SFS_LOCK_GOOD)) begin
            lock_q <= 1'b1; // R9
         end else begin
            good_q <= good_q + 1'b1;
         end
      end
   end

   // Narrow low pulses while the pump fires in lock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_indicator <= 1'b0;
      end else begin
         lock_indicator <= lock_q && !pump_busy; // R9
      end
   end

   // Monitor toggles per divided RF event, giving a square wave
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         monitor_out <= 1'b0;
      end else if (rf_evt_q) begin
         monitor_out <= !monitor_out; // R10
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   assign events[`SFS_ST_REFLOAD] = ref_load;
   assign events[`SFS_ST_RFLOAD] = rf_load;
   assign events[`SFS_ST_LOCKLOST] = lock_lost;
   assign events[`SFS_ST_PDENTER] = pd_enter;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= '0;
      end else if (reg_wr && hit(reg_addr, `SFS_OFF_STATUS)) begin
         status_q <= (status_q & ~reg_wdata[`SFS_ST_W-1:0]) | events;
      end else begin
         status_q <= status_q | events;
      end
   end

   // Mask register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= '0;
      end else if (reg_wr && hit(reg_addr, `SFS_OFF_MASK)) begin
         mask_q <= reg_wdata[`SFS_ST_W-1:0];
      end
   end

   assign irq = |(status_q & mask_q);

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            if (hit(reg_addr, `SFS_OFF_STATUS)) begin
               reg_rdata <= {28'h000_0000, status_q};
            end else if (hit(reg_addr, `SFS_OFF_MASK)) begin
               reg_rdata <= {28'h000_0000, mask_q};
            end else if (hit(reg_addr, `SFS_OFF_STATE)) begin
               reg_rdata <= {26'h000_0000, pwr_q, lock_q, pump_busy, loop_switch_out,
                  lvl[sfs_pkg::PIN_POL]};
            end else if (hit(reg_addr, `SFS_OFF_REFDIV)) begin
               reg_rdata <= {18'h0_0000, ref_div_q};
            end else if (hit(reg_addr, `SFS_OFF_RFDIV)) begin
               reg_rdata <= {14'h0000, rf_div_q};
            end
         end
      end
   end
endmodule : sfs_top

// ### tb/sfs_top_checker.sv
// Port assertions for the serial load and control top.
// Assumes one mclk domain with asynchronous active low reset.
`timescale 1ns/1ps
module sfs_top_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Watched pins
   input wire logic load_strobe,
   input wire logic power_save_n,
   input wire logic pump_src,
   input wire logic pump_snk,
   input wire logic loop_switch_out,
   input wire logic pump_drain_out,
   input wire logic pump_drain_oe,
   input wire logic pump_logic_out,
   input wire logic lock_indicator,
   input wire logic powered_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Switch tracks strobe within the pin sync delay
   sw_close_a: assert property (load_strobe [*6] |-> loop_switch_out)
      else $error("loop switch open under high strobe");
   sw_open_a: assert property (!load_strobe [*8] |-> !loop_switch_out)
      else $error("loop switch closed under low strobe");
   // Reset preloads a high strobe level, so skip the first edges
   sw_cause_a: assert property ($rose(loop_switch_out) && $past(rst_n, 4)
      |-> $past(load_strobe, 2))
      else $error("loop switch closed without strobe");
   // Open drain only ever pulls down
   drain_low_a: assert property (pump_drain_out == 1'b0)
      else $error("open drain output driven high");
   drain_oe_a: assert property (pump_snk == $past(pump_snk)
      |-> pump_drain_oe == pump_snk)
      else $error("open drain enable off sink drive");
   push_pull_a: assert property (pump_src == $past(pump_src)
      |-> pump_logic_out == pump_src)
      else $error("logic output off source drive");
   // A busy pump rules out lock
   lock_drop_a: assert property ((pump_src || pump_snk) [*2] |-> !lock_indicator)
      else $error("lock shown while pump busy");
   run_awake_a: assert property (power_save_n [*8] |-> !powered_down)
      else $error("powered down with power save high");
   down_idle_a: assert property (powered_down |-> !pump_src && !pump_snk)
      else $error("pump active while powered down");
endmodule : sfs_top_checker

bind sfs_top sfs_top_checker u_chk (
   .mclk(mclk),
   .rst_n(rst_n),
   .load_strobe(load_strobe),
   .power_save_n(power_save_n),
   .pump_src(pump_src),
   .pump_snk(pump_snk),
   .loop_switch_out(loop_switch_out),
   .pump_drain_out(pump_drain_out),
   .pump_drain_oe(pump_drain_oe),
   .pump_logic_out(pump_logic_out),
   .lock_indicator(lock_indicator),
   .powered_down(powered_down)
);

// ### tb/sfs_host.sv
// Behavioural host driving the three-wire serial load port.
// Assumes the block oversamples these pins with its own clock.
`timescale 1ns/1ps
module sfs_host (
   // Serial port
   output logic ser_clk,
   output logic ser_data,
   output logic load_strobe
);
   // Idle: clock parked low between frames
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b1;
      load_strobe = 1'b0;
   end
   // One frame at 64 ns per bit; data moves only while clock is low
   task automatic send(input logic [18:0] w);
      // Quarter period off the mclk grid so no pin moves on a clock edge
      #1.25;
      for (int i = 18; i >= 0; i--) begin
         ser_data = w[i];
         #32 ser_clk = 1'b1;
         #32 ser_clk = 1'b0;
      end
      // No pull on data, so show the inverse once released
      ser_data = ~w[0];
      #32 load_strobe = 1'b1;
      #96 load_strobe = 1'b0;
      #32;
   endtask : send
endmodule : sfs_host

// ### tb/sfs_top_bench.sv
// Self-checking bench for the serial load and control top.
// Assumes the host model and the bound checker in the same run.
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_top_bench;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic pol = 1'b1;
   logic psn = 1'b1;
   logic osc = 1'b0;
   logic rf = 1'b0;
   logic osc_on = 1'b0;
   logic rf_on = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rd_d = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] seed = 32'h0000_005E;
   logic [31:0] r;
   logic ser_clk, ser_data, load_strobe, irq, lock, mon, mon_p, pdn, src, snk;
   logic [31:0] exp_q[$];
   int bad_count = 0;
   int checks_done = 0;
   int ph = 0;
   int n;

   sfs_host host (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
   sfs_top dut (
      .mclk(mclk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_strobe(load_strobe), .phase_polarity_select(pol), .power_save_n(psn),
      .osc_ref_in(osc), .rf_in(rf), .pump_src(src), .pump_snk(snk),
      .loop_switch_out(), .pump_drain_out(), .pump_drain_oe(), .pump_logic_out(),
      .lock_indicator(lock), .monitor_out(mon), .powered_down(pdn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   always #2.5 mclk = ~mclk;

   // Sources: reference 20 MHz, RF 10 MHz, both gated
   always @(posedge mclk) begin
      ph <= ph + 1;
      if (osc_on && ph % 5 == 4) osc <= ~osc;
      if (rf_on && ph % 10 == 9) rf <= ~rf;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   task automatic results();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // Let an edge pass so a following write raises the strobe afresh
      @(posedge mclk);
   endtask : wr

   // Read notes its expectation; the watcher below compares
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask : rd

   // Bounded wait on the power down pin
   task automatic wait_pdn(input logic v);
      for (n = 0; n < 3000 && pdn !== v; n++) @(posedge mclk);
      if (n == 3000) begin
         bad_count++;
         results();
      end
   endtask : wait_pdn

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d) cmp(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end

   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(`SFS_OFF_REFDIV, 32'h0000_000A);
      rd(`SFS_OFF_RFDIV, 32'h0000_0064);
      rd(8'h40, 32'h0000_0000);
      wr(`SFS_OFF_MASK, 32'h0000_000F);
      r = rnd();
      host.send({4'h0, r[13:0], 1'b1});
      repeat (8) @(posedge mclk);
      rd(`SFS_OFF_REFDIV, {18'h0_0000, r[13:0]});
      rd(`SFS_OFF_STATUS, 32'h0000_0001);
      cmp({31'h0, irq}, 32'h0000_0001);
      wr(`SFS_OFF_STATUS, 32'h0000_0001);
      rd(`SFS_OFF_STATUS, 32'h0000_0000);
      cmp({31'h0, irq}, 32'h0000_0000);
      host.send({4'h0, 14'h0_00A, 1'b1});
      host.send({18'h0_0005, 1'b0});
      repeat (8) @(posedge mclk);
      rd(`SFS_OFF_RFDIV, 32'h0000_0005);
      // Reference alone leaves the pump stuck in one sense
      osc_on <= 1'b1;
      repeat (400) @(posedge mclk);
      cmp({30'h0, src, snk}, 32'h0000_0002);
      cmp({31'h0, lock}, 32'h0000_0000);
      pol <= 1'b0;
      repeat (20) @(posedge mclk);
      cmp({30'h0, src, snk}, 32'h0000_0001);
      pol <= 1'b1;
      repeat (20) @(posedge mclk);
      rd(`SFS_OFF_STATUS, 32'h0000_0003);
      wr(`SFS_OFF_MASK, 32'h0000_0000);
      @(posedge mclk);
      cmp({31'h0, irq}, 32'h0000_0000);
      wr(`SFS_OFF_STATUS, 32'h0000_000F);
      wr(`SFS_OFF_MASK, 32'h0000_000F);
      // Power save must wait for the busy pump
      psn <= 1'b0;
      repeat (200) @(posedge mclk);
      cmp({31'h0, pdn}, 32'h0000_0000);
      rd(`SFS_OFF_STATE, 32'h0000_0015);
      rf_on <= 1'b1;
      wait_pdn(1'b1);
      rd(`SFS_OFF_STATUS, 32'h0000_0008);
      cmp({31'h0, irq}, 32'h0000_0001);
      psn <= 1'b1;
      wait_pdn(1'b0);
      // Monitor toggles once per divided RF event, every 100 cycles
      repeat (300) @(posedge mclk);
      n = 0;
      mon_p = mon;
      repeat (1000) begin
         @(posedge mclk);
         if (mon !== mon_p) n++;
         mon_p = mon;
      end
      cmp({31'h0, n >= 9 && n <= 11}, 32'h0000_0001);
      results();
   end
endmodule : sfs_top_bench
